// File: strobe_power_sequencer.sv
// Strobe power sequencer: AXI4-Lite registers, strobe engine, supervisor
// Assumes synchronous inputs; analog parts consume the control outputs
//
// How it works
// - Ten strobes, nine delays order power-up
// - Each rail holds one strobe number
// - Rails sharing a strobe switch together
// - Strobe gaps span 2 ms to 5 ms
// - Software rewrites strobe order and delays
// - Software switches rails, switches, GPIOs directly
// - Lockout and supervisor thresholds are writable
// - Switch faults latch as readable flags
// - Strict mode adds overvoltage checking
// - One good output for five rails
// - Separate good output for backup pair
// - Coin-cell condition readable in status
// - Buck voltages and forced PWM writable
// - First two bucks slew toward target
// - Filter mode rejects spikes to 50 ns
// - Strobe one at once, then gaps
// - Strobe zero rails are never touched
// - Power-down reverses order, gaps times ten
// - Off reached 500 ms after power-down
`default_nettype none
module strobe_power_sequencer
    import sequencer_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic wake_req,
    input wire logic sleep_req,
    input wire logic coin_cell_ok,
    input wire switch_fault_s switch_fault,
    input wire rail_sense_s rail_sense,
    output logic [NUM_RAILS-1:0] rail_enable,
    output logic [NUM_GPIO-1:0] gpio_out,
    output logic [3:0] force_pwm,
    output logic [23:0] thresholds,
    output logic [17:0] vout_default,
    output logic [11:0] dvs_level,
    output logic main_rails_good,
    output logic backup_rails_good
);
    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NUM_RAILS-1:0] rail_en;
        logic [NUM_GPIO-1:0] gpio;
        logic strict;
        logic filter;
        logic [3:0] pwm;
        logic [1:0] slew;
        logic [4*NUM_RAILS-1:0] assign_map;
        logic [17:0] delays;
        logic [23:0] thresh;
        logic [17:0] vout;
        logic [11:0] dvs_target;
        logic [11:0] dvs_now;
        logic [1:0][9:0] slew_cnt;
        logic [1:0][2:0] req_cnt;
        logic [1:0] req_filt;
        logic [3*NUM_SW-1:0] sw_flags;
        power_state_e phase;
        logic [3:0] strobe;
        logic tmr_start;
        logic [8:0] tmr_load;
        logic fence_start;
    } state_s;
    state_s q, n;
    logic tmr_done, fence_done, busy, up_go, down_go, main_good, backup_good;
    logic [31:0] wd, status, clear_word;
    logic [3*NUM_SW-1:0] sw_clear;
    logic [1:0] req_raw;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic reg_mapped(input logic [11:0] a);
        return a[1:0] == 2'h0 && a <= OFF_SW_FLAGS;
    endfunction : reg_mapped

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[8*i+:8] = {8{strb[i]}};
        end
        return m;
    endfunction : lane_mask

    function automatic logic [NUM_RAILS-1:0] fire(input logic [NUM_RAILS-1:0] en,
        input logic [4*NUM_RAILS-1:0] asg, input logic [3:0] s, input logic on);
        logic [NUM_RAILS-1:0] r;
        r = en;
        for (int i = 0; i < NUM_RAILS; i++) begin
            if (asg[4*i+:4] == s) begin
                r[i] = on;
            end
        end
        return r;
    endfunction : fire

    // Gap after strobe idx; coded 0..3 for 2..5 ms
    function automatic logic [8:0] gap_ms(input logic [17:0] d, input logic [3:0] idx, input logic down);
        logic [8:0] ms;
        ms = 9'(d[2*(int'(idx)-1)+:2]) + 9'(DELAY_MIN_MS);
        return down ? 9'(int'(ms) * DOWN_FACTOR) : ms;
    endfunction : gap_ms

    function automatic logic [31:0] reg_read(input state_s s, input logic [11:0] a, input logic [31:0] st);
        case (a)
            OFF_ENABLE: return 32'(s.rail_en);
            OFF_GPIO: return 32'(s.gpio);
            OFF_CTRL: return 32'({s.slew, s.pwm, s.filter, s.strict, 2'h0});
            OFF_STATUS: return st;
            OFF_ASSIGN_LO: return s.assign_map[31:0];
            OFF_ASSIGN_HI: return 32'(s.assign_map[39:32]);
            OFF_DELAYS: return 32'(s.delays);
            OFF_THRESH: return 32'(s.thresh);
            OFF_VOUT: return 32'(s.vout);
            OFF_DVS: return 32'(s.dvs_target);
            OFF_SW_FLAGS: return 32'(s.sw_flags);
            default: return 32'h00000000;
        endcase
    endfunction : reg_read

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = q;
        n.tmr_start = 1'b0;
        n.fence_start = 1'b0;
        busy = (q.phase == PWR_UP) || (q.phase == PWR_DOWN);
        status = '0;
        status[STAT_BUSY] = busy;
        status[STAT_PHASE+:2] = q.phase;
        status[STAT_MAIN_GOOD] = main_good;
        status[STAT_BACKUP_GOOD] = backup_good;
        status[STAT_COIN_OK] = coin_cell_ok;
        status[STAT_STROBE+:4] = q.strobe;
        req_raw = {sleep_req, wake_req};
        for (int i = 0; i < 2; i++) begin
            if (req_raw[i] == q.req_filt[i]) begin
                n.req_cnt[i] = 3'h0;
            end else if (!q.filter || q.req_cnt[i] == 3'(SPIKE_CYCLES)) begin
                n.req_filt[i] = req_raw[i];
                n.req_cnt[i] = 3'h0;
            end else begin
                n.req_cnt[i] = q.req_cnt[i] + 3'h1;
            end
        end
        up_go = n.req_filt[0] & ~q.req_filt[0];
        down_go = n.req_filt[1] & ~q.req_filt[1];
        sw_clear = '0;
        clear_word = q.w_data & lane_mask(q.w_strb);
        wd = (reg_read(q, q.aw_addr, status) & ~lane_mask(q.w_strb)) | (q.w_data & lane_mask(q.w_strb));
        // Write channel: address and data taken in either order
        if (q.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (awvalid && q.awready) begin
            n.aw_held = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && q.wready) begin
            n.w_held = 1'b1;
            n.w_data = wdata;
            n.w_strb = wstrb;
        end
        if (q.aw_held && q.w_held && !q.bvalid) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = reg_mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (q.aw_addr)
                OFF_ENABLE: begin
                    if (busy) begin
                        n.bresp = RESP_SLVERR;
                    end else begin
                        n.rail_en = wd[NUM_RAILS-1:0];
                    end
                end
                OFF_GPIO: n.gpio = wd[NUM_GPIO-1:0];
                OFF_CTRL: begin
                    up_go = up_go | wd[CTRL_UP];
                    down_go = down_go | wd[CTRL_DOWN];
                    n.strict = wd[CTRL_STRICT];
                    n.filter = wd[CTRL_FILTER];
                    n.pwm = wd[CTRL_PWM+:4];
                    n.slew = wd[CTRL_SLEW+:2];
                end
                OFF_ASSIGN_LO: n.assign_map[31:0] = wd;
                OFF_ASSIGN_HI: n.assign_map[39:32] = wd[7:0];
                OFF_DELAYS: n.delays = wd[17:0];
                OFF_THRESH: n.thresh = wd[23:0];
                OFF_VOUT: n.vout = wd[17:0];
                OFF_DVS: n.dvs_target = wd[11:0];
                OFF_SW_FLAGS: sw_clear = clear_word[3*NUM_SW-1:0];
                default: ;
            endcase
        end
        n.awready = !n.aw_held && !n.bvalid;
        n.wready = !n.w_held && !n.bvalid;
        // Read channel: one read outstanding
        if (q.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rdata = reg_read(q, araddr, status);
            n.rresp = reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        n.arready = !n.rvalid;
        // New fault beats a clear in the same cycle
        n.sw_flags = (q.sw_flags & ~sw_clear) | switch_fault;
        // Strobe engine
        case (q.phase)
            PWR_OFF: begin
                if (up_go) begin
                    n.phase = PWR_UP;
                    n.strobe = FIRST_STROBE;
                    n.rail_en = fire(n.rail_en, q.assign_map, FIRST_STROBE, 1'b1);
                    n.tmr_start = 1'b1;
                    n.tmr_load = gap_ms(q.delays, FIRST_STROBE, 1'b0);
                end
            end
            PWR_UP: begin
                if (tmr_done) begin
                    n.strobe = q.strobe + 4'h1;
                    n.rail_en = fire(q.rail_en, q.assign_map, n.strobe, 1'b1);
                    if (n.strobe == LAST_STROBE) begin
                        n.phase = PWR_ON;
                    end else begin
                        n.tmr_start = 1'b1;
                        n.tmr_load = gap_ms(q.delays, n.strobe, 1'b0);
                    end
                end
            end
            PWR_ON: begin
                if (down_go) begin
                    n.phase = PWR_DOWN;
                    n.strobe = LAST_STROBE;
                    n.rail_en = fire(n.rail_en, q.assign_map, LAST_STROBE, 1'b0);
                    n.tmr_start = 1'b1;
                    n.tmr_load = gap_ms(q.delays, LAST_STROBE - 4'h1, 1'b1);
                    n.fence_start = 1'b1;
                end
            end
            PWR_DOWN: begin
                if (tmr_done && q.strobe != FIRST_STROBE) begin
                    n.strobe = q.strobe - 4'h1;
                    n.rail_en = fire(q.rail_en, q.assign_map, n.strobe, 1'b0);
                    if (n.strobe != FIRST_STROBE) begin
                        n.tmr_start = 1'b1;
                        n.tmr_load = gap_ms(q.delays, n.strobe - 4'h1, 1'b1);
                    end
                end
                // Fixed fence ends the phase whatever the gaps add up to
                if (fence_done) begin
                    n.phase = PWR_OFF;
                end
            end
            default: n.phase = PWR_OFF;
        endcase
        // Voltage scaling: one code step per slew period
        for (int i = 0; i < 2; i++) begin
            if (q.dvs_now[6*i+:6] == q.dvs_target[6*i+:6]) begin
                n.slew_cnt[i] = 10'h000;
            end else if (q.slew_cnt[i] == 10'((SLEW_CYCLES << q.slew) - 1)) begin
                n.slew_cnt[i] = 10'h000;
                n.dvs_now[6*i+:6] = (q.dvs_now[6*i+:6] < q.dvs_target[6*i+:6]) ?
                    q.dvs_now[6*i+:6] + 6'h01 : q.dvs_now[6*i+:6] - 6'h01;
            end else begin
                n.slew_cnt[i] = q.slew_cnt[i] + 10'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.assign_map <= ASSIGN_RST;
            q.delays <= DELAYS_RST;
            q.thresh <= THRESH_RST;
            q.vout <= VOUT_RST;
            q.phase <= PWR_OFF;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // Timers and supervisor
    // ****************************************
    strobe_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) gap_timer (
        .aclk(aclk), .aresetn(aresetn), .start(q.tmr_start), .ms_load(q.tmr_load), .done(tmr_done));
    strobe_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) fence_timer (
        .aclk(aclk), .aresetn(aresetn), .start(q.fence_start), .ms_load(9'(DOWN_FENCE_MS)),
        .done(fence_done));
    rail_supervisor supervisor (
        .aclk(aclk), .aresetn(aresetn), .enable(q.rail_en[NUM_MON-1:0]), .strict(q.strict),
        .sense(rail_sense), .main_good(main_good), .backup_good(backup_good));

    assign {awready, wready, bvalid, bresp} = {q.awready, q.wready, q.bvalid, q.bresp};
    assign {arready, rvalid, rdata, rresp} = {q.arready, q.rvalid, q.rdata, q.rresp};
    assign rail_enable = q.rail_en;
    assign gpio_out = q.gpio;
    assign force_pwm = q.pwm;
    assign thresholds = q.thresh;
    assign vout_default = q.vout;
    assign dvs_level = q.dvs_now;
    assign main_rails_good = main_good;
    assign backup_rails_good = backup_good;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_write_due;
        q.aw_held && q.w_held && !q.bvalid;
    endsequence
    sequence s_up_start;
        q.phase == PWR_OFF && up_go;
    endsequence
    a_enable_locked: assert property (s_write_due and busy && q.aw_addr == OFF_ENABLE
        |=> bvalid && bresp == RESP_SLVERR) else $error("enable write not refused");
    a_first_strobe: assert property (s_up_start |=> q.phase == PWR_UP && q.strobe == FIRST_STROBE
        ##1 q.tmr_load == gap_ms(q.delays, FIRST_STROBE, 1'b0)) else $error("first strobe wrong");
    a_last_strobe: assert property (q.phase == PWR_UP && tmr_done && q.strobe == 4'h9
        |=> q.phase == PWR_ON && q.strobe == LAST_STROBE) else $error("ten strobes not run");
    a_down_reverse: assert property (q.phase == PWR_DOWN && tmr_done && q.strobe != FIRST_STROBE
        |=> q.strobe == $past(q.strobe) - 4'h1) else $error("down order wrong");
    a_unassigned_kept: assert property (busy && q.assign_map[3:0] == 4'h0
        |=> rail_enable[0] == $past(rail_enable[0])) else $error("unassigned rail moved");
    a_shared_strobe: assert property (q.phase == PWR_UP && tmr_done
        && q.assign_map[3:0] == q.strobe + 4'h1 && q.assign_map[7:4] == q.strobe + 4'h1
        |=> rail_enable[1:0] == 2'h3) else $error("shared strobe split");
    a_fence_exit: assert property (fence_done |=> q.phase == PWR_OFF) else $error("fence missed");
    a_flag_sticky: assert property (switch_fault[0] |=> q.sw_flags[0]) else $error("fault flag lost");
    a_unmapped_err: assert property (s_write_due and !reg_mapped(q.aw_addr)
        |=> bvalid && bresp == RESP_SLVERR) else $error("unmapped write accepted");
endmodule : strobe_power_sequencer
`default_nettype wire

// File: sequencer_pkg.sv
// Shared constants and carriers of the strobe power sequencer
// Assumes one 100 MHz clock and register access over AXI4-Lite
`default_nettype none
package sequencer_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_RAILS = 10;
    localparam int NUM_MON = 5;
    localparam int NUM_SW = 3;
    localparam int NUM_GPIO = 3;
    localparam logic [3:0] FIRST_STROBE = 4'h1;
    localparam logic [3:0] LAST_STROBE = 4'ha;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_MIN_MS = 2;
    localparam int DELAY_MAX_MS = 5;
    localparam int DOWN_FACTOR = 10;
    localparam int DOWN_FENCE_MS = 500;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYCLES = SPIKE_NS / CLK_PERIOD_NS;
    localparam int SLEW_STEP_NS = 1000;
    localparam int SLEW_CYCLES = SLEW_STEP_NS / CLK_PERIOD_NS;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OFF_ENABLE = 12'h000;
    localparam logic [11:0] OFF_GPIO = 12'h004;
    localparam logic [11:0] OFF_CTRL = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_ASSIGN_LO = 12'h010;
    localparam logic [11:0] OFF_ASSIGN_HI = 12'h014;
    localparam logic [11:0] OFF_DELAYS = 12'h018;
    localparam logic [11:0] OFF_THRESH = 12'h01c;
    localparam logic [11:0] OFF_VOUT = 12'h020;
    localparam logic [11:0] OFF_DVS = 12'h024;
    localparam logic [11:0] OFF_SW_FLAGS = 12'h028;
    localparam int CTRL_UP = 0;
    localparam int CTRL_DOWN = 1;
    localparam int CTRL_STRICT = 2;
    localparam int CTRL_FILTER = 3;
    localparam int CTRL_PWM = 4;
    localparam int CTRL_SLEW = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PHASE = 1;
    localparam int STAT_MAIN_GOOD = 3;
    localparam int STAT_BACKUP_GOOD = 4;
    localparam int STAT_COIN_OK = 5;
    localparam int STAT_STROBE = 8;
    localparam logic [39:0] ASSIGN_RST = 40'h21a9876543;
    localparam logic [17:0] DELAYS_RST = 18'h00000;
    localparam logic [23:0] THRESH_RST = 24'h000000;
    localparam logic [17:0] VOUT_RST = 18'h00000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {PWR_OFF, PWR_UP, PWR_ON, PWR_DOWN} power_state_e;
    typedef struct packed {
        logic [NUM_SW-1:0] overtemp;
        logic [NUM_SW-1:0] overcurrent;
        logic [NUM_SW-1:0] undervolt;
    } switch_fault_s;
    typedef struct packed {
        logic [NUM_MON-1:0] under;
        logic [NUM_MON-1:0] over;
        logic [1:0] backup_under;
    } rail_sense_s;
endpackage : sequencer_pkg
`default_nettype wire

// File: strobe_delay_timer.sv
// Millisecond one-shot timer for strobe gaps and the power-down fence
// Assumes start is a one-cycle pulse and ms_load is stable with it
`default_nettype none
module strobe_delay_timer
    import sequencer_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [8:0] ms_load,
    output logic done
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    typedef struct packed {
        logic [PW-1:0] pre;
        logic [8:0] left;
        logic run;
        logic done;
    } timer_s;
    timer_s q, n;
    int elapsed;
    int load_q;

    // ****************************************
    // Countdown, restarted by every start
    // ****************************************
    always_comb begin
        n = q;
        n.done = 1'b0;
        if (start) begin
            n.pre = '0;
            n.left = ms_load;
            n.run = (ms_load != 9'h000);
        end else if (q.run) begin
            if (q.pre == PW'(TICK_CYCLES - 1)) begin
                n.pre = '0;
                n.left = q.left - 9'h001;
                if (q.left == 9'h001) begin
                    n.run = 1'b0;
                    n.done = 1'b1;
                end
            end else begin
                n.pre = q.pre + PW'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            elapsed <= 0;
            load_q <= 0;
        end else begin
            q <= n;
            elapsed <= start ? 0 : elapsed + 1;
            load_q <= start ? int'(ms_load) : load_q;
        end
    end

    assign done = q.done;

    a_timer_exact: assert property (@(posedge aclk) disable iff (!aresetn)
        q.done |-> elapsed == load_q * TICK_CYCLES) else $error("delay length wrong");
endmodule : strobe_delay_timer
`default_nettype wire

// File: rail_supervisor.sv
// Window supervisor for the five monitored rails and the backup pair
// Assumes comparator flags arrive already synchronous to aclk
`default_nettype none
module rail_supervisor
    import sequencer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_MON-1:0] enable,
    input wire logic strict,
    input wire rail_sense_s sense,
    output logic main_good,
    output logic backup_good
);
    typedef struct packed {
        logic main_good;
        logic backup_good;
    } sup_s;
    sup_s q, n;
    logic [NUM_MON-1:0] fault;

    always_comb begin
        n = q;
        fault = enable & (sense.under | (strict ? sense.over : '0));
        n.main_good = ~|fault;
        n.backup_good = ~|sense.backup_under;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign main_good = q.main_good;
    assign backup_good = q.backup_good;

    a_main_under: assert property (@(posedge aclk) disable iff (!aresetn)
        |(enable & sense.under) |=> !main_good) else $error("undervolt not reported");
    a_strict_over: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(enable & sense.over)) |=> (main_good == (!$past(strict) && $past(~|(enable & sense.under)))))
        else $error("overvolt handling wrong");
    a_backup_track: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 backup_good == $past(~|sense.backup_under)) else $error("backup good wrong");
endmodule : rail_supervisor
`default_nettype wire

// File: rail_model.sv
// Rail model: turns rail enables into supervisor window flags
// Assumes a rail that is off sits below its window
`default_nettype none
module rail_model
    import sequencer_pkg::*;
(
    input wire logic [NUM_RAILS-1:0] rail_enable,
    input wire logic droop,
    input wire logic bump,
    output rail_sense_s rail_sense
);
    // Droop pulls every main rail low at once
    assign rail_sense.under = ~rail_enable[NUM_MON-1:0] | {NUM_MON{droop}};
    assign rail_sense.over = {NUM_MON{bump}};
    assign rail_sense.backup_under = ~rail_enable[9:8];
endmodule : rail_model
`default_nettype wire

// File: strobe_power_sequencer_tb_top.sv
// Testbench: AXI4-Lite tasks drive the sequencer through its rules
// Assumes TICK_CYCLES of 20 so a millisecond is 20 cycles
`default_nettype none
module strobe_power_sequencer_tb_top;
    import sequencer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, droop = 0;
    logic wake = 0, sleep = 0, coin = 1, bump = 0;
    logic [2:0] gpio;
    logic [3:0] pwm;
    logic [23:0] th;
    logic [17:0] vo;
    logic [11:0] dvs;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, mg, bg;
    switch_fault_s switch_fault = '0;
    rail_sense_s rail_sense;
    logic [NUM_RAILS-1:0] rail_enable;
    int failures = 0, compares = 0, cyc = 0, t0;
    strobe_power_sequencer #(.TICK_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .wake_req(wake), .sleep_req(sleep),
        .coin_cell_ok(coin), .switch_fault(switch_fault), .rail_sense(rail_sense), .rail_enable(rail_enable),
        .gpio_out(gpio), .force_pwm(pwm), .thresholds(th), .vout_default(vo), .dvs_level(dvs), .main_rails_good(mg),
        .backup_rails_good(bg));
    rail_model far (.rail_enable(rail_enable), .droop(droop), .bump(bump), .rail_sense(rail_sense));
    initial begin
        forever #5 aclk = ~aclk;
    end
    // Ceiling covers the 500 ms fence plus polling slack
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask : wr
    task rd(input logic [11:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = rdata; r = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask : rd
    task wait_phase(input logic [1:0] ph);
        t0 = cyc;
        do rd(OFF_STATUS); while (d[2:1] !== ph);
    endtask : wait_phase
    task wrap_up();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(OFF_ASSIGN_LO); chk(d, 32'ha9876543, "assign_lo");
        rd(OFF_ASSIGN_HI); chk(d, 32'h00000021, "assign_hi");
        rd(12'h0fc); chk(r, RESP_SLVERR, "unmapped");
        wr(12'h0fc, 32'h00000000); chk(r, RESP_SLVERR, "unmapped wr");
        // Rails 0 and 1 share strobe 3; every gap at its longest
        wr(OFF_ASSIGN_LO, 32'ha9876533);
        wr(OFF_DELAYS, 32'h0003ffff);
        wr(OFF_GPIO, 32'h00000005); chk(gpio, 3'h5, "gpio");
        wr(OFF_THRESH, 32'h00abcdef); chk(th, 24'habcdef, "thresh");
        wr(OFF_VOUT, 32'h0002a5a5); chk(vo, 18'h2a5a5, "vout");
        wr(OFF_DVS, 32'h00000042);
        wr(OFF_CTRL, 32'h000000a1); chk(pwm, 4'ha, "pwm");
        chk(rail_enable, 10'h100, "strobe one");
        wr(OFF_ENABLE, 32'h00000000); chk(r, RESP_SLVERR, "enable locked");
        wait_phase(2'h2);
        chk(rail_enable, 10'h3ff, "all up");
        chk(cyc - t0 >= 9 * DELAY_MAX_MS * 20 - 10, 1'b1, "gap length");
        chk(mg, 1'b1, "main good");
        chk(bg, 1'b1, "backup good");
        chk(d[5], 1'b1, "coin ok");
        chk(dvs, 12'h042, "dvs");
        droop <= 1;
        repeat (3) @(posedge aclk);
        chk(mg, 1'b0, "main drop");
        droop <= 0;
        bump <= 1;
        repeat (3) @(posedge aclk);
        chk(mg, 1'b1, "lax over");
        wr(OFF_CTRL, 32'h00000004); chk(mg, 1'b0, "strict over");
        bump <= 0;
        switch_fault <= 9'h101;
        @(posedge aclk);
        switch_fault <= '0;
        rd(OFF_SW_FLAGS); chk(d, 32'h00000101, "fault flag");
        wr(OFF_SW_FLAGS, 32'h00000101); rd(OFF_SW_FLAGS); chk(d, 32'h0, "flag clear");
        wr(OFF_ENABLE, 32'h000003fe); chk(rail_enable, 10'h3fe, "direct off");
        // Rail 0 leaves the sequencer and is switched back on by hand
        wr(OFF_ASSIGN_LO, 32'ha9876530); wr(OFF_ENABLE, 32'h000003ff);
        sleep <= 1;
        coin <= 0;
        wait_phase(2'h0);
        chk(cyc - t0 >= DOWN_FENCE_MS * 20, 1'b1, "fence");
        chk(rail_enable, 10'h001, "all down");
        chk(bg, 1'b0, "backup off");
        chk(d[5], 1'b0, "coin low");
        // Filter on: a 5-cycle wake pulse is a spike, a longer one is taken
        wr(OFF_CTRL, 32'h00000008);
        wake <= 1;
        repeat (5) @(posedge aclk);
        wake <= 0;
        rd(OFF_STATUS); chk(d[2:1], 2'h0, "spike");
        wake <= 1;
        repeat (8) @(posedge aclk);
        rd(OFF_STATUS); chk(d[2:1], 2'h1, "wake");
        wrap_up();
    end
endmodule : strobe_power_sequencer_tb_top
`default_nettype wire
